// ===== hdl/acr_i2c_regs.sv
// two-wire serial slave with the amplifier configuration register bank
`timescale 1ns/1ps

// Notes on behaviour
// R1: after address with write direction, register address byte is received and acknowledged.
// R2: master restarts by stop then start, or repeated start, before reading.
// R3: address resent with direction bit 1 is acknowledged by the device.
// R4: each read byte carries the eight bits of the addressed register.
// R5: register pointer advances by one after each acknowledge bit of a read.
// R6: master ends a read with a stop condition.
// R7: slave address is 10110 followed by the two strap pin levels.
// R8: offsets above 0x09 are test only; they read zero and ignore writes.
// R9: reading offset 0x00 returns the fixed identity value.
// R10: writing 0xAA to offset 0x00 restores every configuration register default.
// R11: soft enable bit 2 of 0x01, default 0, gates only the output stage run and step-up run outputs.
// R12: stage enable bit 1 and boost bit 0 default 1; boost frozen while enabled.
// R13: offset 0x04 holds a three bit current limit, upper bits zero.
// R14: after address with direction 0, register address byte is taken and acknowledged.
// R15: during writes the target address increments after each data byte.
// R16: master acknowledges read bytes except the last, which it leaves unacknowledged.
// R17: reserved bits of writable registers read their fixed defaults whatever is written.
module acr_i2c_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial bus pins, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output acr_pkg::acr_sda_drv_t sda_drv,
  // address strap pins
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  // configuration to the amplifier
  output acr_pkg::acr_cfg_t cfg,
  output logic bus_busy
);

  // three-stage synchronisers for the pins: scl, sda, strap high, strap low
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] pin_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;

  // serial engine state
  acr_pkg::acr_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic master_ack_ff;
  logic sda_oe_ff;
  logic busy_ff;

  // register storage, index is the offset
  logic [7:0] regs_ff [1:9];
  acr_pkg::acr_cfg_t cfg_ff;

  // bus events
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic [7:0] ptr_next;
  logic [7:0] rd_cur;
  logic [7:0] rd_next;
  logic [7:0] sys_merged;

  // read data for an offset; unmapped offsets read zero
  function automatic logic [7:0] read_reg(input logic [7:0] ofs);
    logic [7:0] val;
    val = 8'h00;
    if (ofs == acr_pkg::OFS_IDENTITY)
      val = acr_pkg::IDENTITY_VALUE; // see R9
    else if (ofs <= acr_pkg::OFS_LAST)
      val = regs_ff[ofs[3:0]]; // see R4
    return val;
  endfunction

  // merge written bits with fixed reserved bits
  function automatic logic [7:0] merge_reg(input logic [3:0] idx, input logic [7:0] wdat);
    logic [7:0] val;
    val = (wdat & acr_pkg::REG_WMASK[idx]) | (acr_pkg::REG_DEFAULT[idx] & ~acr_pkg::REG_WMASK[idx]);
    return val;
  endfunction

  // synchroniser chain, first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      sync3_ff <= 4'hF;
    end
    else
    begin
      sync1_ff <= {scl_in, sda_in, addr_strap_high, addr_strap_low};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a pin level is accepted once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pin_ff <= 4'hF;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (sync2_ff[i] == sync3_ff[i])
          pin_ff[i] <= sync3_ff[i];
      end
    end
  end

  // previous filtered levels for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_prev_ff <= pin_ff[3];
      sda_prev_ff <= pin_ff[2];
    end
  end

  // edge and condition decode
  assign scl_f = pin_ff[3];
  assign sda_f = pin_ff[2];
  assign scl_rise = scl_f & ~scl_prev_ff;
  assign scl_fall = ~scl_f & scl_prev_ff;
  assign start_cond = scl_f & scl_prev_ff & sda_prev_ff & ~sda_f;
  assign stop_cond = scl_f & scl_prev_ff & ~sda_prev_ff & sda_f;
  assign addr_match = (shift_ff[7:1] == {acr_pkg::SLAVE_ADDR_PREFIX, pin_ff[1], pin_ff[0]}); // see R7

  // a data byte is complete at the falling edge after its eighth bit
  assign wr_strobe = (state_ff == acr_pkg::ST_WDATA) && scl_fall && (bit_cnt_ff == acr_pkg::BITS_PER_BYTE);
  assign wr_data = shift_ff;
  assign sys_merged = merge_reg(4'h1, wr_data);

  // read data at the pointer and at the following offset, the latter for burst reloads
  assign ptr_next = ptr_ff + 8'h01;
  always_comb
  begin
    rd_cur = read_reg(ptr_ff);
    rd_next = read_reg(ptr_next);
  end

  // serial state machine
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_ff <= acr_pkg::ST_IDLE;
    else if (start_cond)
      state_ff <= acr_pkg::ST_ADDR; // repeated start also lands here, see R2
    else if (stop_cond)
      state_ff <= acr_pkg::ST_IDLE; // see R6
    else if (scl_fall)
    begin
      case (state_ff)
        acr_pkg::ST_ADDR:
        begin
          if (bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
            state_ff <= addr_match ? acr_pkg::ST_ADDR_ACK : acr_pkg::ST_IDLE;
        end
        acr_pkg::ST_ADDR_ACK:
          state_ff <= rw_ff ? acr_pkg::ST_RDATA : acr_pkg::ST_REG; // see R3
        acr_pkg::ST_REG:
        begin
          if (bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
            state_ff <= acr_pkg::ST_REG_ACK; // see R1
        end
        acr_pkg::ST_REG_ACK:
          state_ff <= acr_pkg::ST_WDATA;
        acr_pkg::ST_WDATA:
        begin
          if (bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
            state_ff <= acr_pkg::ST_WDATA_ACK;
        end
        acr_pkg::ST_WDATA_ACK:
          state_ff <= acr_pkg::ST_WDATA;
        acr_pkg::ST_RDATA:
        begin
          if (bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
            state_ff <= acr_pkg::ST_RDATA_ACK;
        end
        acr_pkg::ST_RDATA_ACK:
          state_ff <= master_ack_ff ? acr_pkg::ST_RDATA : acr_pkg::ST_IDLE; // see R16
        default:
          state_ff <= acr_pkg::ST_IDLE;
      endcase
    end
  end

  // bit counter: counts sampled or sent bits, cleared at each byte boundary
  always_ff @(posedge sys_clk)
  begin
    if (rst || start_cond || stop_cond)
      bit_cnt_ff <= 4'h0;
    else if (scl_rise && state_ff != acr_pkg::ST_IDLE)
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    else if (scl_fall && bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
      bit_cnt_ff <= 4'h0;
    else if (scl_fall && (state_ff == acr_pkg::ST_ADDR_ACK || state_ff == acr_pkg::ST_REG_ACK ||
                          state_ff == acr_pkg::ST_WDATA_ACK || state_ff == acr_pkg::ST_RDATA_ACK))
      bit_cnt_ff <= 4'h0;
  end

  // shift register: samples on rising edges, reloads and shifts out on falling edges when reading
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      shift_ff <= 8'h00;
    else if (scl_rise && (state_ff == acr_pkg::ST_ADDR || state_ff == acr_pkg::ST_REG ||
                          state_ff == acr_pkg::ST_WDATA))
      shift_ff <= {shift_ff[6:0], sda_f};
    else if (scl_fall && state_ff == acr_pkg::ST_ADDR_ACK && rw_ff)
      shift_ff <= rd_cur; // see R4
    else if (scl_fall && state_ff == acr_pkg::ST_RDATA_ACK)
      shift_ff <= rd_next; // pointer advances on this same edge, see R5
    else if (scl_fall && state_ff == acr_pkg::ST_RDATA && bit_cnt_ff != 4'h0)
      shift_ff <= {shift_ff[6:0], 1'b0};
  end

  // direction bit of the address byte
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rw_ff <= 1'b0;
    else if (scl_fall && state_ff == acr_pkg::ST_ADDR && bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
      rw_ff <= shift_ff[0];
  end

  // acknowledge from the master, sampled in the ninth bit of a read byte
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      master_ack_ff <= 1'b0;
    else if (scl_rise && state_ff == acr_pkg::ST_RDATA_ACK)
      master_ack_ff <= ~sda_f;
  end

  // register pointer: loaded from the register address byte, advanced after each data byte acknowledge bit
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ptr_ff <= 8'h00;
    else if (scl_fall && state_ff == acr_pkg::ST_REG && bit_cnt_ff == acr_pkg::BITS_PER_BYTE)
      ptr_ff <= shift_ff; // see R14
    else if (scl_fall && (state_ff == acr_pkg::ST_WDATA_ACK || state_ff == acr_pkg::ST_RDATA_ACK))
      ptr_ff <= ptr_ff + 8'h01; // see R5, see R15
  end

  // data pin driver: low for acknowledges, data bits while reading
  always_ff @(posedge sys_clk)
  begin
    if (rst || start_cond || stop_cond)
      sda_oe_ff <= 1'b0;
    else if (scl_fall)
    begin
      case (state_ff)
        acr_pkg::ST_ADDR:
          sda_oe_ff <= (bit_cnt_ff == acr_pkg::BITS_PER_BYTE) && addr_match; // see R3, see R14
        acr_pkg::ST_REG:
          sda_oe_ff <= (bit_cnt_ff == acr_pkg::BITS_PER_BYTE); // see R1
        acr_pkg::ST_WDATA:
          sda_oe_ff <= (bit_cnt_ff == acr_pkg::BITS_PER_BYTE);
        acr_pkg::ST_ADDR_ACK:
          sda_oe_ff <= rw_ff && !rd_cur[7];
        acr_pkg::ST_RDATA:
          sda_oe_ff <= (bit_cnt_ff != acr_pkg::BITS_PER_BYTE) && !shift_ff[6];
        acr_pkg::ST_RDATA_ACK:
          sda_oe_ff <= master_ack_ff && !rd_next[7]; // see R5
        default:
          sda_oe_ff <= 1'b0;
      endcase
    end
  end

  // transaction in progress between start and stop
  always_ff @(posedge sys_clk)
  begin
    if (rst || stop_cond)
      busy_ff <= 1'b0;
    else if (start_cond)
      busy_ff <= 1'b1;
  end

  // register writes; identity write of the key restores defaults
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 1; i <= 9; i++)
        regs_ff[i] <= acr_pkg::REG_DEFAULT[i];
    end
    else if (wr_strobe)
    begin
      if (ptr_ff == acr_pkg::OFS_IDENTITY)
      begin
        if (wr_data == acr_pkg::SOFT_RESET_KEY)
        begin
          for (int i = 1; i <= 9; i++)
            regs_ff[i] <= acr_pkg::REG_DEFAULT[i]; // see R10
        end
      end
      else if (ptr_ff == acr_pkg::OFS_SYS_CTRL)
      begin
        // boost bit held while the chip is soft enabled
        if (regs_ff[1][acr_pkg::SYS_SOFT_EN_BIT])
          regs_ff[1] <= {sys_merged[7:1], regs_ff[1][acr_pkg::SYS_BOOST_EN_BIT]}; // see R12
        else
          regs_ff[1] <= sys_merged; // see R11, see R12
      end
      else if (ptr_ff <= acr_pkg::OFS_LAST)
        regs_ff[ptr_ff[3:0]] <= merge_reg(ptr_ff[3:0], wr_data); // see R13, see R17
      // offsets above the last are ignored, see R8
    end
  end

  // configuration outputs, registered from the bank
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_ff <= '0;
    else
    begin
      cfg_ff.chip_soft_enable <= regs_ff[1][acr_pkg::SYS_SOFT_EN_BIT];
      cfg_ff.output_stage_enable <= regs_ff[1][acr_pkg::SYS_STAGE_EN_BIT];
      cfg_ff.boost_enable <= regs_ff[1][acr_pkg::SYS_BOOST_EN_BIT];
      // blocks run only while soft enabled
      cfg_ff.output_stage_run <= regs_ff[1][acr_pkg::SYS_SOFT_EN_BIT] &
                                 regs_ff[1][acr_pkg::SYS_STAGE_EN_BIT]; // see R11
      cfg_ff.step_up_run <= regs_ff[1][acr_pkg::SYS_SOFT_EN_BIT] &
                            regs_ff[1][acr_pkg::SYS_BOOST_EN_BIT]; // see R11
      cfg_ff.battery_guard_threshold <= regs_ff[2][4:3];
      cfg_ff.battery_guard_soft_enable <= regs_ff[2][2];
      cfg_ff.battery_guard_max_level <= regs_ff[2][1:0];
      cfg_ff.step_up_voltage_sel <= regs_ff[3][2:0];
      cfg_ff.coil_current_limit <= regs_ff[4][2:0]; // see R13
      cfg_ff.output_stage_gain <= regs_ff[5][3:0];
      cfg_ff.level_ctrl_three_power <= regs_ff[6][3:0];
      cfg_ff.level_ctrl_three_release <= regs_ff[7][7:5];
      cfg_ff.level_ctrl_three_attack <= regs_ff[7][4:2];
      cfg_ff.level_ctrl_two_power <= regs_ff[8][7:5];
      cfg_ff.level_ctrl_two_attack <= regs_ff[8][4:2];
      cfg_ff.level_ctrl_one_attack <= regs_ff[9][2:1];
      cfg_ff.level_ctrl_one_powerdown <= regs_ff[9][0];
    end
  end

  // output drive; data pin only ever pulls low
  assign sda_drv = {1'b0, sda_oe_ff};
  assign cfg = cfg_ff;
  assign bus_busy = busy_ff;

endmodule // acr_i2c_regs

// ===== inc/acr_pkg.sv
// package: register map, field layout, reset values and types for the amplifier control register bank
package acr_pkg;

  // register offsets
  localparam logic [7:0] OFS_IDENTITY = 8'h00;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h01;
  localparam logic [7:0] OFS_BAT_GUARD = 8'h02;
  localparam logic [7:0] OFS_STEP_UP_V = 8'h03;
  localparam logic [7:0] OFS_CUR_LIMIT = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h05;
  localparam logic [7:0] OFS_LVL3_POWER = 8'h06;
  localparam logic [7:0] OFS_LVL3_TIMING = 8'h07;
  localparam logic [7:0] OFS_LVL2_CFG = 8'h08;
  localparam logic [7:0] OFS_LVL1_CFG = 8'h09;
  localparam logic [7:0] OFS_LAST = 8'h09;

  // identity value is arbitrary; writing the key restores all defaults
  localparam logic [7:0] IDENTITY_VALUE = 8'h5C;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hAA;

  // reset values, index = offset (entry 0 unused)
  localparam logic [7:0] REG_DEFAULT [0:9] = '{8'h00, 8'h03, 8'h28, 8'h05, 8'h04,
                                               8'h02, 8'h03, 8'h52, 8'h26, 8'h02};
  // writable bits; all others keep their default value
  localparam logic [7:0] REG_WMASK [0:9] = '{8'h00, 8'h07, 8'h1F, 8'h07, 8'h07,
                                             8'h0F, 8'h0F, 8'hFC, 8'hFC, 8'h07};

  // system control bit positions
  localparam int SYS_SOFT_EN_BIT = 2;
  localparam int SYS_STAGE_EN_BIT = 1;
  localparam int SYS_BOOST_EN_BIT = 0;

  // fixed upper five bits of the slave address, strap pins give the low two
  localparam logic [4:0] SLAVE_ADDR_PREFIX = 5'h16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } acr_state_t;

  // decoded configuration handed to the analog blocks
  typedef struct packed {
    logic chip_soft_enable;
    logic output_stage_enable;
    logic boost_enable;
    logic output_stage_run;
    logic step_up_run;
    logic [1:0] battery_guard_threshold;
    logic battery_guard_soft_enable;
    logic [1:0] battery_guard_max_level;
    logic [2:0] step_up_voltage_sel;
    logic [2:0] coil_current_limit;
    logic [3:0] output_stage_gain;
    logic [3:0] level_ctrl_three_power;
    logic [2:0] level_ctrl_three_release;
    logic [2:0] level_ctrl_three_attack;
    logic [2:0] level_ctrl_two_power;
    logic [2:0] level_ctrl_two_attack;
    logic [1:0] level_ctrl_one_attack;
    logic level_ctrl_one_powerdown;
  } acr_cfg_t;

  // open-drain data pin as two signals
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
  } acr_sda_drv_t;

endpackage

// ===== sim/acr_i2c_regs_monitor.sv
// checker on the ports of the serial register bank
`timescale 1ns/1ps
module acr_i2c_regs_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial pins and straps
  input wire logic scl_in,
  input wire logic sda_in,
  input wire acr_pkg::acr_sda_drv_t sda_drv,
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  // configuration and status
  input wire acr_pkg::acr_cfg_t cfg,
  input wire logic bus_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // data pulled only inside a transfer
  property p_oe_in_frame;
    sda_drv.sda_oe |-> bus_busy;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("data pulled outside frame");
  // data changes only while the clock pin is low
  property p_oe_clock_low;
    $changed(sda_drv.sda_oe) |-> !$past(scl_in, 2);
  endproperty
  a_oe_clock_low: assert property (p_oe_clock_low) else $error("data moved with clock high");
  // frame opens on data falling with clock high
  property p_start;
    $rose(bus_busy) |-> $past(scl_in) && !$past(sda_in);
  endproperty
  a_start: assert property (p_start) else $error("busy without start");
  // frame closes on data rising with clock high
  property p_stop;
    $fell(bus_busy) |-> $past(scl_in) && $past(sda_in);
  endproperty
  a_stop: assert property (p_stop) else $error("idle without stop");
  // output stage runs only when chip enabled
  property p_stage_run;
    cfg.output_stage_run == (cfg.chip_soft_enable && cfg.output_stage_enable);
  endproperty
  a_stage_run: assert property (p_stage_run) else $error("stage run mismatch");
  // converter runs only when chip enabled
  property p_step_up_run;
    cfg.step_up_run == (cfg.chip_soft_enable && cfg.boost_enable);
  endproperty
  a_step_up_run: assert property (p_step_up_run) else $error("converter run mismatch");
  // boost bit held while chip stays enabled
  property p_boost_frozen;
    cfg.chip_soft_enable && $past(cfg.chip_soft_enable) |-> cfg.boost_enable == $past(cfg.boost_enable);
  endproperty
  a_boost_frozen: assert property (p_boost_frozen) else $error("boost moved while enabled");
  // configuration moves only through bus writes
  property p_cfg_in_frame;
    $changed(cfg) && !$past(rst, 3) |-> bus_busy || $past(bus_busy);
  endproperty
  a_cfg_in_frame: assert property (p_cfg_in_frame) else $error("config moved outside frame");
endmodule // acr_i2c_regs_monitor

bind acr_i2c_regs acr_i2c_regs_monitor mon (.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_drv(sda_drv), .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high), .cfg(cfg),
  .bus_busy(bus_busy));

// ===== sim/acr_host_model.sv
// host controller model driving the two-wire bus
`timescale 1ns/1ps
module acr_host_model (
  // bus lines, low on sda_m pulls the wire
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  localparam realtime QTR = 31.25;
  // idle bus, both released
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start; long waits let the device release its ack
  task automatic start();
    sda_m = 1'b1;
    #(3*QTR);
    scl = 1'b1;
    #(3*QTR);
    sda_m = 1'b0;
    #(3*QTR);
    scl = 1'b0;
  endtask
  // stop: data rises with clock high
  task automatic stop();
    sda_m = 1'b0;
    #(3*QTR);
    scl = 1'b1;
    #(3*QTR);
    sda_m = 1'b1;
    #(4*QTR);
  endtask
  // one clock pulse of 125 ns
  task automatic bit_xfer(input logic b, output logic seen);
    #(QTR);
    sda_m = b;
    #(QTR);
    scl = 1'b1;
    #(QTR);
    seen = sda;
    #(QTR);
    scl = 1'b0;
  endtask
  // byte to the device msb first, returns ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // byte from the device, the last left unacknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(last, s);
  endtask
endmodule // acr_host_model

// ===== sim/test_acr_i2c_regs.sv
// self-checking bench for the amplifier register bank
`timescale 1ns/1ps
module test_acr_i2c_regs;
  // pins and bookkeeping
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_m;
  logic sda;
  logic strap_lo = 1'b0;
  logic strap_hi = 1'b0;
  acr_pkg::acr_sda_drv_t drv;
  acr_pkg::acr_cfg_t cfg;
  logic busy;
  int n_errors = 0;
  int cmp_count = 0;
  logic [7:0] exp_reg [0:10];

  // clock and open-drain wire with pull-up
  always #5 sys_clk = ~sys_clk;
  assign sda = sda_m & (drv.sda_oe ? drv.sda_out : 1'b1);

  // design and host
  acr_i2c_regs uut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_drv(drv),
    .addr_strap_low(strap_lo), .addr_strap_high(strap_hi), .cfg(cfg), .bus_busy(busy));
  acr_host_model host (.scl(scl), .sda_m(sda_m), .sda(sda));

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // expected image after any reset
  function automatic void set_defaults();
    exp_reg = '{acr_pkg::IDENTITY_VALUE, 8'h03, 8'h28, 8'h05, 8'h04, 8'h02, 8'h03, 8'h52, 8'h26, 8'h02, 8'h00};
  endfunction
  // effect of one written byte
  function automatic void apply(input int k, input logic [7:0] v);
    logic [7:0] old;
    if (k == 0 && v == 8'hAA)
      set_defaults();
    else if (k >= 1 && k <= 9)
    begin
      old = exp_reg[k];
      exp_reg[k] = (old & ~acr_pkg::REG_WMASK[k]) | (v & acr_pkg::REG_WMASK[k]);
      if (k == 1 && old[2])
        exp_reg[1][0] = old[0];
    end
  endfunction
  // configuration image expected from the register image
  function automatic acr_pkg::acr_cfg_t cfg_of();
    acr_pkg::acr_cfg_t c;
    logic [7:0] s;
    s = exp_reg[1];
    c = {s[2], s[1], s[0], s[2] & s[1], s[2] & s[0], exp_reg[2][4:0], exp_reg[3][2:0], exp_reg[4][2:0],
      exp_reg[5][3:0], exp_reg[6][3:0], exp_reg[7][7:2], exp_reg[8][7:2], exp_reg[9][2:0]};
    return c;
  endfunction
  // write burst from an offset
  task automatic write_regs(input logic [7:0] ofs, input logic [7:0] d[$]);
    logic ack;
    host.start();
    host.wbyte({5'h16, strap_hi, strap_lo, 1'b0}, ack);
    check("write address ack", 8'(ack), 8'h01);
    host.wbyte(ofs, ack);
    check("offset ack", 8'(ack), 8'h01);
    foreach (d[i])
    begin
      host.wbyte(d[i], ack);
      check("data ack", 8'(ack), 8'h01);
      apply(ofs + i, d[i]);
    end
    host.stop();
  endtask
  // read burst, restart by stop and start or by repeated start
  task automatic read_regs(input logic [7:0] ofs, input int n, input logic rep);
    logic ack;
    logic [7:0] d;
    host.start();
    host.wbyte({5'h16, strap_hi, strap_lo, 1'b0}, ack);
    host.wbyte(ofs, ack);
    check("read offset ack", 8'(ack), 8'h01);
    if (!rep)
      host.stop();
    host.start();
    host.wbyte({5'h16, strap_hi, strap_lo, 1'b1}, ack);
    check("read address ack", 8'(ack), 8'h01);
    for (int i = 0; i < n; i++)
    begin
      host.rbyte(i == n - 1, d);
      check($sformatf("register %0d", ofs + i), d, exp_reg[(ofs + i > 10) ? 10 : ofs + i]);
    end
    host.stop();
  endtask

  // test sequence
  initial
  begin
    logic [7:0] q[$];
    logic ack;
    int ofs;
    void'($urandom(32'hBCD3));
    {strap_hi, strap_lo} = 2'($urandom);
    set_defaults();
    repeat (4) @(posedge sys_clk);
    #1;
    check("quiet in reset", 8'({busy, drv.sda_oe, cfg != '0}), 8'h00);
    rst = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    check("control bits", 8'({cfg.chip_soft_enable, cfg.output_stage_enable, cfg.boost_enable,
      cfg.output_stage_run, cfg.step_up_run}), 8'h0C);
    check("current limit", 8'(cfg.coil_current_limit), 8'h04);
    read_regs(8'h00, 11, 1'b1);
    $display("test defaults done");
    repeat (6)
    begin
      ofs = 1 + $urandom_range(8);
      q = {};
      repeat (1 + $urandom_range(2))
        q.push_back(8'($urandom));
      write_regs(8'(ofs), q);
      read_regs(8'(ofs), q.size(), 1'($urandom));
      check("config image", 8'(cfg === cfg_of()), 8'h01);
    end
    check("current limit field", 8'(cfg.coil_current_limit), 8'(exp_reg[4][2:0]));
    $display("test random bursts done");
    write_regs(8'h01, '{8'h00});
    write_regs(8'h01, '{8'h07});
    write_regs(8'h01, '{8'h06});
    read_regs(8'h01, 1, 1'b0);
    check("boost held", 8'({cfg.boost_enable, cfg.output_stage_run, cfg.step_up_run}), 8'h07);
    write_regs(8'h00, '{8'h55});
    write_regs(8'h0A, '{8'h3C});
    read_regs(8'h00, 1, 1'b1);
    read_regs(8'h0A, 1, 1'b0);
    write_regs(8'h00, '{8'hAA});
    read_regs(8'h00, 11, 1'b0);
    check("soft reset", 8'({cfg.chip_soft_enable, cfg.output_stage_enable, cfg.boost_enable}), 8'h03);
    check("config after soft reset", 8'(cfg === cfg_of()), 8'h01);
    $display("test protection and soft reset done");
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk);
      #1 {strap_hi, strap_lo} = 2'(s);
      repeat (10) @(posedge sys_clk);
      #1;
      host.start();
      host.wbyte({5'h16, 2'(s) ^ 2'h1, 1'b1}, ack);
      check("foreign address", 8'(ack), 8'h00);
      host.stop();
      read_regs(8'h04, 1, 1'b1);
    end
    $display("test address straps done");
    report_and_stop();
  end

  // watchdog against a hung run
  initial
  begin
    for (int c = 0; c < 60000; c++)
      @(posedge sys_clk);
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule // test_acr_i2c_regs
